// ### rtl/idd_decoder.sv
// Instruction decoder: splits program words into fields and sets the cycle count of each.
`timescale 1ns/1ps
`include "idd_map.svh"

module idd_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_word,
  input wire logic cond_true,
  input wire logic skip_next_two_word,
  output logic fetch_hold,
  output logic exec_nop,
  output idd_pkg::idd_dec_s dec
);

  idd_pkg::idd_state_s st_q;
  idd_pkg::idd_state_s st_d;
  idd_pkg::idd_dec_s dw;
  logic take;
  logic [7:0] opc_in;
  logic [1:0] extra;

  assign take = fetch_valid & ~st_q.fetch_hold;
  assign opc_in = fetch_word[`IDD_OPC_HI:`IDD_OPC_LO];

  // Prefetch code: 0..6 on the even base, 7..13 on the odd base, 14 indexed, 15 none.
  function automatic logic [7:0] pf_map(input logic [3:0] code, input logic [3:0] base);
    logic [3:0] idx;
    logic [3:0] reg_n;
    logic [3:0] step;
    idx = (code >= `IDD_PF_SPLIT) ? code - `IDD_PF_SPLIT : code;
    reg_n = (code >= `IDD_PF_SPLIT) ? base + 4'h1 : base;
    case (idx[2:0])
      3'h0: step = 4'h6;
      3'h1: step = 4'h4;
      3'h2: step = 4'h2;
      3'h4: step = 4'hA;
      3'h5: step = 4'hC;
      3'h6: step = 4'hE;
      default: step = 4'h0;
    endcase
    if (code == `IDD_PF_INDEXED) begin
      step = 4'h0;
    end
    if (code == `IDD_PF_NONE) begin
      reg_n = 4'h0;
      step = 4'h0;
    end
    return {reg_n, step};
  endfunction

  function automatic logic [7:0] mul_pair(input logic [2:0] code);
    case (code)
      3'h1: return {4'h4, 4'h6};
      3'h2: return {4'h4, 4'h7};
      3'h3: return {4'h5, 4'h6};
      3'h4: return {4'h5, 4'h7};
      3'h5: return {4'h6, 4'h7};
      default: return {4'h4, 4'h5};
    endcase
  endfunction

  function automatic logic two_word(input logic [7:0] opc);
    return opc == `IDD_OPC_GOTO_LIT || opc == `IDD_OPC_CALL_LIT ||
      opc == `IDD_OPC_LOOP_LIT;
  endfunction

  function automatic idd_pkg::idd_dec_s decode(input logic [23:0] w, input logic cnd,
      input logic skip2);
    idd_pkg::idd_dec_s d;
    logic [7:0] opc;
    logic [7:0] pf;
    d = '0;
    opc = w[`IDD_OPC_HI:`IDD_OPC_LO];
    d.valid = 1'b1;
    d.opcode = opc;
    d.size = idd_pkg::idd_size_e'(opc[1:0]);
    d.cycles = `IDD_CYC_ONE;
    case (opc[7:5])
      3'h1: begin
        d.cls = idd_pkg::CLS_REGOP;
        d.base_source_reg = w[15:12];
        d.dest_reg = w[11:8];
        d.dest_mode = w[7:6];
        d.second_source_reg = w[5:2];
        d.src_mode = w[1:0];
        d.dest_used = 1'b1;
        if (d.size == idd_pkg::SZ_DOUBLE) begin
          d.cycles = `IDD_CYC_TWO;
        end
      end
      3'h2: begin
        d.cls = idd_pkg::CLS_FILE;
        d.file_addr = w[12:0];
        d.dest_is_file = w[13];
        d.dest_used = 1'b1;
      end
      3'h3: begin
        d.cls = idd_pkg::CLS_BIT;
        d.bit_select_field = w[15:12];
        d.bit_indirect = w[11];
        d.base_source_reg = w[7:4];
        d.second_source_reg = w[3:0];
        d.src_mode = w[9:8];
      end
      3'h4: begin
        d.cls = idd_pkg::CLS_LIT;
        if (opc[2]) begin
          d.base_source_reg = w[15:12];
          d.dest_reg = w[11:8];
          d.ten_bit_literal = {5'h00, w[4:0]};
          d.dest_used = (w[11:8] != w[15:12]);
        end else begin
          d.base_source_reg = w[3:0];
          d.dest_reg = w[3:0];
          d.ten_bit_literal = (d.size == idd_pkg::SZ_BYTE) ? {2'h0, w[11:4]} : w[13:4];
        end
      end
      3'h5: begin
        d.acc_b = w[15];
        if (opc[4]) begin
          d.cls = idd_pkg::CLS_SQR;
          d.mul_a = `IDD_SQR_BASE + {2'h0, w[13:12]};
          d.mul_b = `IDD_SQR_BASE + {2'h0, w[13:12]};
        end else begin
          d.cls = idd_pkg::CLS_MULACC;
          {d.mul_a, d.mul_b} = mul_pair(w[14:12]);
        end
        d.x_code = w[11:8];
        pf = pf_map(w[11:8], `IDD_X_BASE);
        {d.x_reg, d.x_step} = pf;
        d.x_dest = `IDD_SQR_BASE + {2'h0, w[7:6]};
        d.y_code = w[5:2];
        pf = pf_map(w[5:2], `IDD_Y_BASE);
        {d.y_reg, d.y_step} = pf;
        d.y_dest = `IDD_SQR_BASE + {2'h0, w[1:0]};
        d.accum_writeback_dest = `IDD_WB_REG;
        d.wb_indirect = opc[0];
        d.wb_step = opc[0] ? `IDD_WB_STEP : 4'h0;
      end
      3'h6: begin
        d.cls = idd_pkg::CLS_DSP;
        d.acc_b = w[15];
        d.second_source_reg = w[14:11];
        d.src_mode = w[10:9];
        d.shift_by_reg = w[8];
        d.shift_amount_reg = w[3:0];
        d.shift_lit = w[5:0];
      end
      default: begin
        d.cls = (opc == `IDD_OPC_NOP) ? idd_pkg::CLS_NOP : idd_pkg::CLS_CTRL;
        d.size = idd_pkg::SZ_WORD;
        d.program_address_literal = {7'h00, w[15:0]};
        case (opc)
          `IDD_OPC_REL_BRANCH, `IDD_OPC_CALL_IND, `IDD_OPC_GOTO_IND, `IDD_OPC_TABLE_RD,
          `IDD_OPC_TABLE_WR: begin
            d.cycles = `IDD_CYC_TWO;
          end
          `IDD_OPC_RETURN, `IDD_OPC_RET_INT: begin
            d.cycles = `IDD_CYC_THREE;
          end
          `IDD_OPC_COND_BRANCH: begin
            d.cycles = cnd ? `IDD_CYC_TWO : `IDD_CYC_ONE;
          end
          `IDD_OPC_SKIP: begin
            if (cnd) begin
              d.cycles = skip2 ? `IDD_CYC_THREE : `IDD_CYC_TWO;
            end
          end
          default: begin
            d.cycles = `IDD_CYC_ONE;
          end
        endcase
      end
    endcase
    case (d.cls)
      idd_pkg::CLS_MULACC, idd_pkg::CLS_SQR, idd_pkg::CLS_DSP: begin
        d.dsp_flags = `IDD_DSP_FLAGS_ALL;
      end
      idd_pkg::CLS_REGOP, idd_pkg::CLS_FILE, idd_pkg::CLS_BIT, idd_pkg::CLS_LIT: begin
        d.mcu_flags = `IDD_MCU_FLAGS_ALL;
      end
      default: d.mcu_flags = 5'h00;
    endcase
    return d;
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.dec.valid = 1'b0;
    st_d.exec_nop = 1'b0;
    dw = decode(fetch_word, cond_true, skip_next_two_word);
    extra = dw.cycles - 2'h1;
    case (st_q.fsm)
      idd_pkg::S_RUN, idd_pkg::S_EXT: begin
        if (take) begin
          if (st_q.fsm == idd_pkg::S_EXT && opc_in == `IDD_EXT_MARK) begin
            dw = decode(st_q.first_word, 1'b0, 1'b0);
            dw.program_address_literal = {fetch_word[6:0], st_q.first_word[15:0]};
            dw.cycles = `IDD_CYC_TWO;
            extra = 2'h0;
            st_d.dec = dw;
            st_d.fsm = idd_pkg::S_RUN;
          end else if (two_word(opc_in)) begin
            st_d.first_word = fetch_word;
            st_d.fsm = idd_pkg::S_EXT;
            st_d.exec_nop = 1'b1;
            extra = 2'h0;
          end else begin
            st_d.dec = dw;
            st_d.fsm = idd_pkg::S_RUN;
          end
          if (extra != 2'h0) begin
            st_d.fsm = idd_pkg::S_STALL;
            st_d.nop_left = extra;
          end
        end
      end
      idd_pkg::S_STALL: begin
        st_d.exec_nop = 1'b1;
        st_d.nop_left = st_q.nop_left - 2'h1;
        if (st_q.nop_left == 2'h1) begin
          st_d.fsm = idd_pkg::S_RUN;
        end
      end
      default: begin
        st_d.fsm = idd_pkg::S_RUN;
      end
    endcase
    st_d.fetch_hold = (st_d.fsm == idd_pkg::S_STALL);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fetch_hold = st_q.fetch_hold;
  assign exec_nop = st_q.exec_nop;
  assign dec = st_q.dec;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_orphan_ext_nop: assert property (
    take && st_q.fsm == idd_pkg::S_RUN && opc_in == `IDD_EXT_MARK
    |=> dec.valid && dec.cls == idd_pkg::CLS_NOP && dec.mcu_flags == 5'h00)
    else $error("lone extension word not decoded as no-operation");
  chk_two_word_pair: assert property (
    take && two_word(opc_in) ##1 take && opc_in == `IDD_EXT_MARK
    |=> dec.valid && dec.cycles == `IDD_CYC_TWO && !fetch_hold)
    else $error("two-word instruction not issued in two cycles");
  chk_three_cycle_stall: assert property (
    dec.valid && dec.cycles == `IDD_CYC_THREE && fetch_hold
    |=> exec_nop && fetch_hold && !dec.valid ##1 exec_nop && !fetch_hold)
    else $error("three-cycle instruction did not insert two no-operation cycles");
  chk_hold_no_issue: assert property (
    fetch_hold |=> !dec.valid && exec_nop)
    else $error("instruction issued while fetch held");
  chk_skip_two_word: assert property (
    take && st_q.fsm == idd_pkg::S_RUN && opc_in == `IDD_OPC_SKIP && cond_true
    |=> dec.cycles == ($past(skip_next_two_word) ? `IDD_CYC_THREE : `IDD_CYC_TWO))
    else $error("taken skip has wrong cycle count");
  chk_single_cycle: assert property (
    take && st_q.fsm == idd_pkg::S_RUN && opc_in[7:5] == 3'h2
    |=> dec.valid && dec.cycles == `IDD_CYC_ONE ##1 (!exec_nop || $past(take && two_word(opc_in))))
    else $error("file instruction did not complete in one cycle");
  chk_byte_literal: assert property (
    dec.valid && dec.cls == idd_pkg::CLS_LIT && dec.size == idd_pkg::SZ_BYTE
    |-> dec.ten_bit_literal[9:8] == 2'h0)
    else $error("byte-mode literal above 255");
  chk_square_same: assert property (
    dec.valid && dec.cls == idd_pkg::CLS_SQR
    |-> dec.mul_a == dec.mul_b && dec.mul_a >= 4'h4 && dec.mul_a <= 4'h7)
    else $error("square operands differ or out of range");
  chk_prefetch_reg: assert property (
    dec.valid && dec.cls == idd_pkg::CLS_MULACC && dec.x_code != `IDD_PF_NONE
    |-> dec.x_reg == 4'h8 || dec.x_reg == 4'h9)
    else $error("X prefetch uses a register other than 8 or 9");
  chk_flag_masks: assert property (
    dec.valid && dec.cls == idd_pkg::CLS_DSP |-> dec.dsp_flags == 4'hF && dec.mcu_flags == 5'h00)
    else $error("DSP flag mask wrong");
  chk_first_word_nop: assert property (
    take && two_word(opc_in) |=> exec_nop && !dec.valid && !fetch_hold)
    else $error("first word of a pair not shown as a no-operation");
  chk_two_cycle_stall: assert property (
    dec.valid && dec.cycles == `IDD_CYC_TWO && fetch_hold
    |=> exec_nop && !fetch_hold && !dec.valid)
    else $error("two-cycle instruction did not insert one no-operation cycle");
  chk_hold_ends: assert property (
    fetch_hold |-> ##[1:2] !fetch_hold)
    else $error("fetch hold lasted more than two cycles");
  chk_one_cycle_free: assert property (
    dec.valid && dec.cycles == `IDD_CYC_ONE |-> !fetch_hold)
    else $error("one-cycle instruction held the fetch path");
  chk_cond_branch: assert property (
    take && opc_in == `IDD_OPC_COND_BRANCH
    |=> dec.valid && dec.cycles == ($past(cond_true) ? `IDD_CYC_TWO : `IDD_CYC_ONE))
    else $error("conditional branch has wrong cycle count");
  chk_mul_pair: assert property (
    dec.valid && dec.cls == idd_pkg::CLS_MULACC
    |-> dec.mul_a != dec.mul_b && dec.mul_a >= 4'h4 && dec.mul_b <= 4'h7)
    else $error("multiplicand pair repeats a register or is out of range");
  chk_writeback_dest: assert property (
    dec.valid && (dec.cls == idd_pkg::CLS_MULACC || dec.cls == idd_pkg::CLS_SQR)
    |-> dec.accum_writeback_dest == 4'hD && dec.wb_step == (dec.wb_indirect ? 4'h2 : 4'h0))
    else $error("write-back destination not register 13 with a step of 2");
  chk_ctrl_word_size: assert property (
    dec.valid && (dec.cls == idd_pkg::CLS_CTRL || dec.cls == idd_pkg::CLS_NOP)
    |-> dec.size == idd_pkg::SZ_WORD)
    else $error("control instruction not in word size");
  chk_lit_dest_use: assert property (
    dec.valid && dec.cls == idd_pkg::CLS_LIT && dec.opcode[2]
    |-> dec.dest_used == (dec.dest_reg != dec.base_source_reg))
    else $error("literal destination use wrong");
  chk_return_stall: assert property (
    take && opc_in == `IDD_OPC_RETURN
    |=> dec.valid && dec.cycles == `IDD_CYC_THREE && fetch_hold)
    else $error("return not issued as a three-cycle instruction");
  chk_file_flags: assert property (
    dec.valid && dec.cls == idd_pkg::CLS_FILE
    |-> dec.mcu_flags == 5'h1F && dec.dsp_flags == 4'h0)
    else $error("file instruction flag mask wrong");

  cov_two_word: cover property (take && two_word(opc_in) ##1 take ##1 dec.valid);
  cov_return: cover property (dec.valid && dec.opcode == `IDD_OPC_RETURN ##2 exec_nop);
  cov_skip_three: cover property (dec.valid && dec.opcode == `IDD_OPC_SKIP &&
    dec.cycles == `IDD_CYC_THREE);
  cov_orphan: cover property (dec.valid && dec.cls == idd_pkg::CLS_NOP);

endmodule // idd_decoder

// ### rtl/idd_map.svh
// Opcode values, field positions, cycle counts and fixed register numbers of the decoder.
`ifndef IDD_MAP_SVH
`define IDD_MAP_SVH
`define IDD_OPC_HI 23
`define IDD_OPC_LO 16
`define IDD_EXT_MARK 8'h00
`define IDD_OPC_NOP 8'h00
`define IDD_OPC_GOTO_LIT 8'hE0
`define IDD_OPC_CALL_LIT 8'hE1
`define IDD_OPC_LOOP_LIT 8'hE2
`define IDD_OPC_REL_BRANCH 8'hE4
`define IDD_OPC_CALL_IND 8'hE5
`define IDD_OPC_GOTO_IND 8'hE6
`define IDD_OPC_TABLE_RD 8'hE8
`define IDD_OPC_TABLE_WR 8'hE9
`define IDD_OPC_RETURN 8'hEC
`define IDD_OPC_RET_INT 8'hED
`define IDD_OPC_COND_BRANCH 8'hF0
`define IDD_OPC_SKIP 8'hF4
`define IDD_CYC_ONE 2'h1
`define IDD_CYC_TWO 2'h2
`define IDD_CYC_THREE 2'h3
`define IDD_WB_REG 4'hD
`define IDD_WB_STEP 4'h2
`define IDD_SQR_BASE 4'h4
`define IDD_PF_INDEXED 4'hE
`define IDD_PF_NONE 4'hF
`define IDD_PF_SPLIT 4'h7
`define IDD_X_BASE 4'h8
`define IDD_Y_BASE 4'hA
`define IDD_INDEX_REG 4'hC
`define IDD_MCU_FLAGS_ALL 5'h1F
`define IDD_DSP_FLAGS_ALL 4'hF
`endif

// ### rtl/idd_pkg.sv
// Types shared by the instruction decoder: classes, sizes, states and the decoded record.
package idd_pkg;
  typedef enum logic [3:0] {
    CLS_NOP = 4'h0, CLS_REGOP = 4'h1, CLS_FILE = 4'h2, CLS_BIT = 4'h3, CLS_LIT = 4'h4,
    CLS_MULACC = 4'h5, CLS_DSP = 4'h6, CLS_CTRL = 4'h7, CLS_SQR = 4'h8
  } idd_cls_e;
  typedef enum logic [1:0] {
    SZ_WORD = 2'h0, SZ_BYTE = 2'h1, SZ_DOUBLE = 2'h2, SZ_WORD_ALT = 2'h3
  } idd_size_e;
  typedef enum logic [1:0] {
    S_RUN = 2'h0, S_EXT = 2'h1, S_STALL = 2'h2
  } idd_fsm_e;
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    idd_cls_e cls;
    idd_size_e size;
    logic [3:0] base_source_reg;
    logic [3:0] second_source_reg;
    logic [1:0] src_mode;
    logic [3:0] dest_reg;
    logic [1:0] dest_mode;
    logic dest_used;
    logic [12:0] file_addr;
    logic dest_is_file;
    logic [3:0] bit_select_field;
    logic bit_indirect;
    logic [9:0] ten_bit_literal;
    logic acc_b;
    logic [3:0] mul_a;
    logic [3:0] mul_b;
    logic [3:0] x_code;
    logic [3:0] x_reg;
    logic [3:0] x_step;
    logic [3:0] x_dest;
    logic [3:0] y_code;
    logic [3:0] y_reg;
    logic [3:0] y_step;
    logic [3:0] y_dest;
    logic wb_indirect;
    logic [3:0] accum_writeback_dest;
    logic [3:0] wb_step;
    logic shift_by_reg;
    logic [3:0] shift_amount_reg;
    logic [5:0] shift_lit;
    logic [22:0] program_address_literal;
    logic [1:0] cycles;
    logic [4:0] mcu_flags;
    logic [3:0] dsp_flags;
  } idd_dec_s;
  typedef struct packed {
    idd_fsm_e fsm;
    logic [23:0] first_word;
    logic [1:0] nop_left;
    logic fetch_hold;
    logic exec_nop;
    idd_dec_s dec;
  } idd_state_s;
endpackage

// ### tb/idd_fetch_model.sv
// Fetch-side model that offers a short program to the decoder and waits while it is held.
`timescale 1ns/1ps
module idd_fetch_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [2:0] n,
  input wire logic [23:0] prog [4],
  input wire logic fetch_hold,
  output logic fetch_valid,
  output logic [23:0] fetch_word
);
  logic [2:0] idx;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx <= 3'h0;
      fetch_valid <= 1'b0;
      fetch_word <= 24'h000000;
    end else if (go) begin
      idx <= 3'h0;
      fetch_valid <= 1'b1;
      fetch_word <= prog[0];
    end else if (fetch_valid && !fetch_hold) begin
      idx <= idx + 3'h1;
      if (idx + 3'h1 < n) begin
        fetch_word <= prog[idx[1:0] + 2'h1];
      end else begin
        // An idle bus shows a changed word so a stale value is never mistaken for a new one.
        fetch_valid <= 1'b0;
        fetch_word <= ~fetch_word;
      end
    end
  end
endmodule // idd_fetch_model

// ### tb/tb_top.sv
// Self-checking bench for the instruction decoder with a fetch-side model.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [23:0] w;
    logic c;
    logic s;
    idd_pkg::idd_cls_e cls;
    logic [1:0] cy;
  } idd_row_s;
  logic clk, rst, go, cond_true, skip_next_two_word, fetch_valid, fetch_hold, exec_nop;
  logic [2:0] n, nn, nh, pre_nop;
  logic [23:0] fetch_word;
  logic [23:0] prog [4];
  idd_pkg::idd_dec_s dec, d;
  int bad_count, n_tests, cyc;
  idd_row_s rows [20] = '{
    '{24'h2035A5, 1'b0, 1'b0, idd_pkg::CLS_REGOP, 2'h1},
    '{24'h203000, 1'b1, 1'b1, idd_pkg::CLS_REGOP, 2'h1},
    '{24'h220000, 1'b0, 1'b0, idd_pkg::CLS_REGOP, 2'h2},
    '{24'h403ABC, 1'b0, 1'b0, idd_pkg::CLS_FILE, 2'h1},
    '{24'h60F800, 1'b0, 1'b0, idd_pkg::CLS_BIT, 2'h1},
    '{24'h847700, 1'b0, 1'b0, idd_pkg::CLS_LIT, 2'h1},
    '{24'hA18900, 1'b0, 1'b0, idd_pkg::CLS_MULACC, 2'h1},
    '{24'hB03000, 1'b0, 1'b0, idd_pkg::CLS_SQR, 2'h1},
    '{24'hC00105, 1'b0, 1'b0, idd_pkg::CLS_DSP, 2'h1},
    '{24'hE40000, 1'b0, 1'b0, idd_pkg::CLS_CTRL, 2'h2},
    '{24'hE50000, 1'b0, 1'b0, idd_pkg::CLS_CTRL, 2'h2},
    '{24'hE60000, 1'b0, 1'b0, idd_pkg::CLS_CTRL, 2'h2},
    '{24'hE80000, 1'b0, 1'b0, idd_pkg::CLS_CTRL, 2'h2},
    '{24'hE90000, 1'b0, 1'b0, idd_pkg::CLS_CTRL, 2'h2},
    '{24'hEC0000, 1'b0, 1'b0, idd_pkg::CLS_CTRL, 2'h3},
    '{24'hED0000, 1'b0, 1'b0, idd_pkg::CLS_CTRL, 2'h3},
    '{24'hF00000, 1'b1, 1'b0, idd_pkg::CLS_CTRL, 2'h2},
    '{24'hF40000, 1'b1, 1'b0, idd_pkg::CLS_CTRL, 2'h2},
    '{24'hF40000, 1'b1, 1'b1, idd_pkg::CLS_CTRL, 2'h3},
    '{24'h000055, 1'b0, 1'b0, idd_pkg::CLS_NOP, 2'h1}
  };
  idd_decoder idd_decoder_i (.clk(clk), .rst(rst), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .cond_true(cond_true), .skip_next_two_word(skip_next_two_word),
    .fetch_hold(fetch_hold), .exec_nop(exec_nop), .dec(dec));
  idd_fetch_model idd_fetch_model_i (.clk(clk), .rst(rst), .go(go), .n(n), .prog(prog),
    .fetch_hold(fetch_hold), .fetch_valid(fetch_valid), .fetch_word(fetch_word));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Offers k words, waits for the issue, then counts added cycles and held cycles.
  task automatic issue(input logic [23:0] w0, input logic [23:0] w1, input logic [2:0] k,
                       input logic c, input logic s);
    int t;
    @(posedge clk);
    prog[0] <= w0;
    prog[1] <= w1;
    n <= k;
    cond_true <= c;
    skip_next_two_word <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    pre_nop = 3'h0;
    nn = 3'h0;
    t = 0;
    do begin
      @(posedge clk);
      #1;
      t++;
      pre_nop += 3'((dec.valid !== 1'b1) && (exec_nop === 1'b1));
    end while (dec.valid !== 1'b1 && t < 12);
    d = dec;
    nh = 3'(fetch_hold === 1'b1);
    repeat (4) begin
      @(posedge clk);
      #1;
      nh += 3'(fetch_hold === 1'b1);
      nn += 3'(exec_nop === 1'b1);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    go = 1'b0;
    n = 3'h0;
    cond_true = 1'b0;
    skip_next_two_word = 1'b0;
    prog = '{default: 24'h000000};
    repeat (2) @(posedge clk);
    #1;
    chk(32'(|{fetch_hold, exec_nop, dec}), 32'h0);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(|{fetch_hold, exec_nop, dec}), 32'h0);
    foreach (rows[i]) begin
      issue(rows[i].w, 24'h000000, 3'h1, rows[i].c, rows[i].s);
      chk({d.valid, d.cls, d.cycles}, {1'b1, rows[i].cls, rows[i].cy});
      chk({pre_nop, nn, nh}, {3'h0, {2{1'b0, rows[i].cy - 2'h1}}});
    end
    issue(24'h2035A5, 24'h000000, 3'h1, 1'b0, 1'b0);
    chk({d.opcode, d.size}, {8'h20, idd_pkg::SZ_WORD});
    chk({d.base_source_reg, d.second_source_reg, d.src_mode}, {4'h3, 4'h9, 2'h1});
    chk({d.dest_reg, d.dest_mode, d.mcu_flags}, {4'h5, 2'h2, 5'h1F});
    issue(24'h403ABC, 24'h000000, 3'h1, 1'b0, 1'b0);
    chk({d.dest_is_file, d.file_addr}, {1'b1, 13'h1ABC});
    issue(24'h60F800, 24'h000000, 3'h1, 1'b0, 1'b0);
    chk({d.bit_select_field, d.bit_indirect}, {4'hF, 1'b1});
    issue(24'h847700, 24'h000000, 3'h1, 1'b0, 1'b0);
    chk(d.dest_used, 1'b0);
    issue(24'h847600, 24'h000000, 3'h1, 1'b0, 1'b0);
    chk(d.dest_used, 1'b1);
    issue(24'h803FF0, 24'h000000, 3'h1, 1'b0, 1'b0);
    chk(d.ten_bit_literal, 10'h3FF);
    issue(24'h810FF0, 24'h000000, 3'h1, 1'b0, 1'b0);
    chk({d.size, d.ten_bit_literal}, {idd_pkg::SZ_BYTE, 10'h0FF});
    issue(24'hA18900, 24'h000000, 3'h1, 1'b0, 1'b0);
    chk({d.acc_b, d.x_reg, d.x_step, d.dsp_flags}, {1'b1, 4'h9, 4'h2, 4'hF});
    chk({d.wb_indirect, d.accum_writeback_dest, d.wb_step}, {1'b1, 4'hD, 4'h2});
    issue(24'hB03000, 24'h000000, 3'h1, 1'b0, 1'b0);
    chk({d.mul_a, d.mul_b}, {4'h7, 4'h7});
    issue(24'hC00105, 24'h000000, 3'h1, 1'b0, 1'b0);
    chk({d.shift_by_reg, d.shift_amount_reg}, {1'b1, 4'h5});
    issue(24'hE01234, 24'h00007F, 3'h2, 1'b0, 1'b0);
    chk({pre_nop, nn, nh, d.cls, d.cycles}, {9'h040, idd_pkg::CLS_CTRL, 2'h2});
    chk(d.program_address_literal, 23'h7F1234);
    issue(24'hE01234, 24'h2035A5, 3'h2, 1'b0, 1'b0);
    chk({d.valid, d.cls, d.opcode}, {1'b1, idd_pkg::CLS_REGOP, 8'h20});
    // A word offered during a stall waits until the hold drops, then issues once.
    issue(24'hEC0000, 24'h403ABC, 3'h2, 1'b0, 1'b0);
    chk({d.cls, d.cycles}, {idd_pkg::CLS_CTRL, 2'h3});
    chk({nn, nh, dec.cls, dec.file_addr}, {3'h2, 3'h2, idd_pkg::CLS_FILE, 13'h1ABC});
    // A reset in the middle of a stall drops the hold and the pending no-operation cycles.
    @(posedge clk);
    prog[0] <= 24'hED0000;
    n <= 3'h1;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk(32'(|{fetch_hold, exec_nop, dec, fetch_valid}), 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(|{fetch_hold, exec_nop, dec}), 32'h0);
    issue(24'h403ABC, 24'h000000, 3'h1, 1'b0, 1'b0);
    chk({d.valid, d.cls, nn, nh}, {1'b1, idd_pkg::CLS_FILE, 6'h00});
    report_and_stop();
  end
endmodule // tb_top
